// ==== core/control_literal_table_decoder.sv ====
// Control-flow, literal and table instruction decoder with executor
`timescale 1ns/1ps
module control_literal_table_decoder
   import ctl_lit_pkg::*;
#(
   parameter int PC_W = 21
) (
   input  wire logic            clk_i,
   input  wire logic            rst_i,
   input  wire logic            wb_cyc_i,
   input  wire logic            wb_stb_i,
   input  wire logic            wb_we_i,
   input  wire logic [7:0]      wb_adr_i,
   input  wire logic [3:0]      wb_sel_i,
   input  wire logic [31:0]     wb_dat_i,
   output logic      [31:0]     wb_dat_o,
   output logic                 wb_ack_o,
   input  wire logic [15:0]     instr_i,
   input  wire logic            instr_valid_i,
   output logic                 instr_ready_o,
   output logic      [PC_W-1:0] pc_o,
   output logic      [PC_W-1:0] tbl_addr_o,
   output logic                 tbl_rd_o,
   output logic                 tbl_wr_o,
   output logic      [7:0]      tbl_wdata_o,
   input  wire logic [7:0]      tbl_rdata_i,
   input  wire logic            mem_write_done_i,
   output logic                 mem_write_busy_o,
   output logic                 sleep_o,
   output logic                 wdt_clear_o,
   output logic                 soft_reset_o,
   input  wire logic [7:0]      port_pins_i,
   input  wire logic            port_rmw_i,
   output logic      [7:0]      port_rmw_data_o,
   input  wire logic            timer_write_i,
   input  wire logic            prescaler_assigned_i,
   output logic                 prescaler_clear_o
);
   // ==========================================================
   // Functions
   // Eight-bit add giving {ov, dc, c, sum}
   function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b,
                                        input logic cin);
      logic [8:0] s;
      logic [4:0] h;
      s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      return {(a[7] == b[7]) && (s[7] != a[7]), h[4], s[8], s[7:0]};
   endfunction
   // Branch condition from ccc field
   function automatic logic cond_true(input logic [2:0] ccc, input flags_t f);
      logic v;
      case (ccc[2:1])
         2'b00:   v = f.z;
         2'b01:   v = f.c;
         2'b10:   v = f.ov;
         default: v = f.n;
      endcase
      return v ^ ccc[0];
   endfunction
   // Decimal adjust giving {carry, result}
   function automatic logic [8:0] dec_adj(input logic [7:0] w, input flags_t f);
      logic [8:0] t;
      t = {1'b0, w};
      if (w[3:0] > 4'h9 || f.dc) begin
         t = t + 9'h006;
      end
      if (t[7:4] > 4'h9 || f.c || t[8]) begin
         t = t + 9'h060;
      end
      return t;
   endfunction

   // ==========================================================
   // State
   dec_state_t          state;
   flags_t              flags;
   flags_t              sh_flags;
   logic [7:0]          acc;
   logic [7:0]          sh_acc;
   logic [7:0]          bank;
   logic [7:0]          sh_bank;
   logic [PC_W-1:0]     pc;
   logic [PC_W-1:0]     tblptr;
   logic [7:0]          tbllat;
   logic [15:0]         prod;
   logic [11:0]         ptr [3];
   logic [PC_W-1:0]     stack [STACK_DEPTH];
   logic [4:0]          sp;
   logic [1:0]          ctrl;
   logic                timeout_flag;
   logic                power_down_flag;
   logic                global_ie;
   logic                periph_ie;
   logic                soft_rst;
   logic                tbl_rd_pend;
   logic [2:0]          twait_cnt;
   pend_op_t            pend_op;
   logic [7:0]          pend_low;
   logic                pend_s;

   // ==========================================================
   // Decode
   wire logic [15:0] w        = instr_i;
   wire logic        fire     = (state == ST_EXEC) && instr_valid_i && ctrl[CTRL_RUN_BIT];
   wire logic        fire2    = (state == ST_WORD2) && instr_valid_i && ctrl[CTRL_RUN_BIT];
   wire logic        is_bcond = w[15:11] == 5'b11100;
   wire logic        is_rjmp  = w[15:11] == 5'b11010;
   wire logic        is_rcl   = w[15:11] == 5'b11011;
   wire logic        is_call  = w[15:9] == 7'b1110110;
   wire logic        is_ajmp  = w[15:8] == 8'hef;
   wire logic        is_pload = w[15:6] == 10'b1110111000;
   wire logic        is_lit   = w[15:11] == 5'b00001;
   wire logic        is_bload = w[15:4] == 12'h010;
   wire logic        is_misc  = w[15:8] == 8'h00;
   wire logic        is_ret   = w[15:1] == 15'h0009;
   wire logic        is_iret  = w[15:1] == 15'h0008;
   wire logic        is_trd   = w[15:2] == 14'h0002;
   wire logic        is_twr   = w[15:2] == 14'h0003;
   wire logic        cond_take = is_bcond && cond_true(w[10:8], flags);
   wire logic [PC_W-1:0] pc_p2 = pc + 21'd2;
   wire logic [PC_W-1:0] off8  = {{12{w[7]}}, w[7:0], 1'b0};
   wire logic [PC_W-1:0] off11 = {{9{w[10]}}, w[10:0], 1'b0};
   wire logic [PC_W-1:0] far   = {w[11:0], pend_low, 1'b0};
   wire logic [4:0]      sp_m1 = sp - 5'd1;
   wire logic [10:0]     add_r = add8(acc, w[7:0], 1'b0);
   wire logic [10:0]     sub_r = add8(w[7:0], ~acc, 1'b1);
   wire logic [8:0]      dadj_r = dec_adj(acc, flags);
   wire logic [PC_W-1:0] tbl_a = (w[1:0] == 2'b11) ? tblptr + 21'd1 : tblptr;
   wire logic            long_wr = fire && is_twr && ctrl[CTRL_LWEN_BIT];
   wire logic            rst_all = rst_i || soft_rst;

   // Handshake outputs
   assign instr_ready_o = ctrl[CTRL_RUN_BIT] && (state == ST_EXEC || state == ST_WORD2);
   assign pc_o          = pc;
   assign soft_reset_o  = soft_rst;

   // ==========================================================
   // Instruction execution
   always_ff @(posedge clk_i) begin
      tbl_rd_o    <= 1'b0;
      tbl_wr_o    <= 1'b0;
      wdt_clear_o <= 1'b0;
      soft_rst    <= 1'b0;
      if (rst_all) begin
         state <= ST_EXEC;
         flags <= '0;
         sh_flags <= '0;
         acc <= 8'h00;
         sh_acc <= 8'h00;
         bank <= 8'h00;
         sh_bank <= 8'h00;
         pc <= '0;
         tblptr <= '0;
         tbllat <= 8'h00;
         prod <= 16'h0000;
         ptr <= '{default: 12'h000};
         sp <= 5'd0;
         timeout_flag <= 1'b1;
         power_down_flag <= 1'b1;
         global_ie <= 1'b0;
         periph_ie <= 1'b0;
         sleep_o <= 1'b0;
         tbl_rd_pend <= 1'b0;
         twait_cnt <= 3'd0;
         pend_op <= PEND_CALL;
         pend_low <= 8'h00;
         pend_s <= 1'b0;
         tbl_addr_o <= '0;
         tbl_wdata_o <= 8'h00;
      end else if (fire) begin
         pc <= pc_p2;
         if (is_bcond) begin
            if (cond_take) begin
               pc <= pc_p2 + off8;
               state <= ST_FLUSH;
            end
         end else if (is_rjmp || is_rcl) begin
            pc <= pc_p2 + off11;
            state <= ST_FLUSH;
            if (is_rcl) begin
               stack[sp] <= pc_p2;
               sp <= sp + 5'd1;
            end
         end else if (is_call || is_ajmp || is_pload) begin
            pend_op <= is_pload ? PEND_PTR : (is_ajmp ? PEND_JUMP : PEND_CALL);
            pend_low <= w[7:0];
            pend_s <= w[8];
            state <= ST_WORD2;
         end else if (is_ret || is_iret) begin
            pc <= stack[sp_m1];
            sp <= sp_m1;
            state <= ST_FLUSH;
            if (w[0]) begin
               flags <= sh_flags;
               acc <= sh_acc;
               bank <= sh_bank;
            end
            if (is_iret) begin
               global_ie <= 1'b1;
            end
         end else if (is_trd) begin
            tbl_addr_o <= tbl_a;
            tbl_rd_o <= 1'b1;
            tbl_rd_pend <= 1'b1;
            state <= ST_FLUSH;
            case (w[1:0])
               2'b01:   tblptr <= tblptr + 21'd1;
               2'b10:   tblptr <= tblptr - 21'd1;
               2'b11:   tblptr <= tbl_a;
               default: tblptr <= tblptr;
            endcase
         end else if (is_twr) begin
            tbl_addr_o <= tbl_a;
            tbl_wdata_o <= tbllat;
            tbl_wr_o <= 1'b1;
            state <= long_wr ? ST_TWAIT : ST_FLUSH;
            twait_cnt <= 3'(TWR_LONG_CYCLES - 2);
            case (w[1:0])
               2'b01:   tblptr <= tblptr + 21'd1;
               2'b10:   tblptr <= tblptr - 21'd1;
               2'b11:   tblptr <= tbl_a;
               default: tblptr <= tblptr;
            endcase
         end else if (is_lit) begin
            case (w[11:8])
               4'hf: begin
                  acc <= add_r[7:0];
                  flags <= '{n: add_r[7], ov: add_r[10], z: add_r[7:0] == 8'h00,
                             dc: add_r[9], c: add_r[8]};
               end
               4'h8: begin
                  acc <= sub_r[7:0];
                  flags <= '{n: sub_r[7], ov: sub_r[10], z: sub_r[7:0] == 8'h00,
                             dc: sub_r[9], c: sub_r[8]};
               end
               4'hb, 4'h9, 4'ha: begin
                  acc <= (w[11:8] == 4'hb) ? (acc & w[7:0]) :
                         (w[11:8] == 4'h9) ? (acc | w[7:0]) : (acc ^ w[7:0]);
                  flags.z <= ((w[11:8] == 4'hb) ? (acc & w[7:0]) :
                             (w[11:8] == 4'h9) ? (acc | w[7:0]) :
                             (acc ^ w[7:0])) == 8'h00;
                  flags.n <= (w[11:8] == 4'hb) ? (acc[7] & w[7]) :
                             (w[11:8] == 4'h9) ? (acc[7] | w[7]) : (acc[7] ^ w[7]);
               end
               4'he: acc <= w[7:0];
               4'hd: prod <= acc * w[7:0];
               4'hc: begin
                  acc <= w[7:0];
                  pc <= stack[sp_m1];
                  sp <= sp_m1;
                  state <= ST_FLUSH;
               end
               default: acc <= acc;
            endcase
         end else if (is_bload) begin
            bank[3:0] <= w[3:0];
         end else if (is_misc) begin
            case (w[7:0])
               8'h03: begin
                  sleep_o <= 1'b1;
                  timeout_flag <= 1'b1;
                  power_down_flag <= 1'b0;
               end
               8'h04: begin
                  wdt_clear_o <= 1'b1;
                  timeout_flag <= 1'b1;
                  power_down_flag <= 1'b1;
               end
               8'h05: begin
                  stack[sp] <= pc_p2;
                  sp <= sp + 5'd1;
               end
               8'h06: sp <= sp_m1;
               8'h07: begin
                  acc <= dadj_r[7:0];
                  flags.c <= dadj_r[8];
               end
               8'hff: soft_rst <= 1'b1;
               default: acc <= acc;
            endcase
         end
         // Words starting 1111 and unlisted words fall through as no-ops
      end else if (fire2) begin
         state <= ST_FLUSH;
         pc <= pc_p2;
         case (pend_op)
            PEND_PTR: begin
               ptr[pend_low[5:4]] <= {pend_low[3:0], w[7:0]};
               state <= ST_EXEC;
            end
            PEND_JUMP: pc <= far;
            default: begin
               pc <= far;
               stack[sp] <= pc_p2;
               sp <= sp + 5'd1;
               if (pend_s) begin
                  sh_flags <= flags;
                  sh_acc <= acc;
                  sh_bank <= bank;
               end
            end
         endcase
      end else if (state == ST_FLUSH) begin
         state <= ST_EXEC;
         if (tbl_rd_pend) begin
            tbllat <= tbl_rdata_i;
            tbl_rd_pend <= 1'b0;
         end
      end else if (state == ST_TWAIT) begin
         twait_cnt <= twait_cnt - 3'd1;
         if (twait_cnt == 3'd0) begin
            state <= ST_EXEC;
         end
      end
   end

   // ==========================================================
   // Launched memory write stays busy until terminated
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mem_write_busy_o <= 1'b0;
      end else if (long_wr) begin
         mem_write_busy_o <= 1'b1;
      end else if (mem_write_done_i) begin
         mem_write_busy_o <= 1'b0;
      end
   end

   // Port and timer side effects of file writes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port_rmw_data_o <= 8'h00;
         prescaler_clear_o <= 1'b0;
      end else begin
         if (port_rmw_i) begin
            port_rmw_data_o <= port_pins_i;
         end
         prescaler_clear_o <= timer_write_i && prescaler_assigned_i;
      end
   end

   // ==========================================================
   // Wishbone slave: single-cycle ack, unmapped reads zero
   wire logic        wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire logic [31:0] rd_mux =
      (wb_adr_i == ADR_CTRL)   ? {30'h0, ctrl} :
      (wb_adr_i == ADR_STATUS) ? {20'h0, mem_write_busy_o, sleep_o, global_ie, periph_ie,
                                  timeout_flag, power_down_flag, 1'b0, flags} :
      (wb_adr_i == ADR_ACC)    ? {24'h0, acc} :
      (wb_adr_i == ADR_BANK)   ? {24'h0, bank} :
      (wb_adr_i == ADR_PC)     ? {11'h0, pc} :
      (wb_adr_i == ADR_TBLPTR) ? {11'h0, tblptr} :
      (wb_adr_i == ADR_TBLLAT) ? {24'h0, tbllat} :
      (wb_adr_i == ADR_PROD)   ? {16'h0, prod} :
      (wb_adr_i == ADR_PTR0)   ? {20'h0, ptr[0]} :
      (wb_adr_i == ADR_PTR1)   ? {20'h0, ptr[1]} :
      (wb_adr_i == ADR_PTR2)   ? {20'h0, ptr[2]} : 32'h0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
         ctrl <= CTRL_RESET;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= wb_req ? rd_mux : 32'h0;
         if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_CTRL) begin
            ctrl <= wb_dat_i[1:0];
         end
      end
   end

   // ==========================================================
   // Assertions
   sequence seq_cond_taken;
      fire && cond_take;
   endsequence
   sequence seq_call_pair;
      fire && is_call ##1 fire2;
   endsequence

   AST_BRANCH_TAKEN: assert property (@(posedge clk_i) disable iff (rst_all)
      seq_cond_taken |=> state == ST_FLUSH ##1 state == ST_EXEC)
      else $error("taken branch did not take two cycles");
   AST_BRANCH_FLAGS: assert property (@(posedge clk_i) disable iff (rst_all)
      fire && is_bcond |=> flags == $past(flags))
      else $error("branch altered flags");
   AST_BRANCH_PC: assert property (@(posedge clk_i) disable iff (rst_all)
      fire && is_bcond && !cond_take |=> state == ST_EXEC && pc == $past(pc) + 21'd2)
      else $error("untaken branch misbehaved");
   AST_CALL_PUSH: assert property (@(posedge clk_i) disable iff (rst_all)
      seq_call_pair |=> sp == $past(sp) + 5'd1 && state == ST_FLUSH)
      else $error("call did not push");
   AST_LIT_RETURN_LOAD: assert property (@(posedge clk_i) disable iff (rst_all)
      fire && is_lit && w[11:8] == 4'hc |=> acc == $past(w[7:0]) && sp == $past(sp) - 5'd1)
      else $error("literal return wrong");
   AST_WATCHDOG_CLEAR: assert property (@(posedge clk_i) disable iff (rst_all)
      fire && is_misc && w[7:0] == 8'h04 |=> timeout_flag && power_down_flag && wdt_clear_o)
      else $error("watchdog clear flags wrong");
   AST_SECOND_NOP: assert property (@(posedge clk_i) disable iff (rst_all)
      fire && w[15:12] == 4'hf |=> acc == $past(acc) && state == ST_EXEC)
      else $error("second word not a no-op");
   AST_TABLE_WRITE_LONG: assert property (@(posedge clk_i) disable iff (rst_all)
      long_wr |=> (state == ST_TWAIT)[*4] ##1 state == ST_EXEC)
      else $error("long table write not five cycles");
   AST_MEM_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      mem_write_busy_o && !mem_write_done_i |=> mem_write_busy_o)
      else $error("memory write abandoned");
   AST_PRESCALER: assert property (@(posedge clk_i) disable iff (rst_i)
      timer_write_i && prescaler_assigned_i |=> prescaler_clear_o)
      else $error("prescaler not cleared");
endmodule

// ==== core/ctl_lit_pkg.sv ====
// Constants, types and encodings shared by the control and literal decoder
package ctl_lit_pkg;
   // ==========================================================
   // Register map (byte addresses)
   localparam logic [7:0] ADR_CTRL    = 8'h00;
   localparam logic [7:0] ADR_STATUS  = 8'h04;
   localparam logic [7:0] ADR_ACC     = 8'h08;
   localparam logic [7:0] ADR_BANK    = 8'h0c;
   localparam logic [7:0] ADR_PC      = 8'h10;
   localparam logic [7:0] ADR_TBLPTR  = 8'h14;
   localparam logic [7:0] ADR_TBLLAT  = 8'h18;
   localparam logic [7:0] ADR_PROD    = 8'h1c;
   localparam logic [7:0] ADR_PTR0    = 8'h20;
   localparam logic [7:0] ADR_PTR1    = 8'h24;
   localparam logic [7:0] ADR_PTR2    = 8'h28;
   // Control bits
   localparam int CTRL_RUN_BIT   = 0;
   localparam int CTRL_LWEN_BIT  = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   // Timing and stack depth
   localparam int TWR_LONG_CYCLES   = 5;
   localparam int STACK_DEPTH       = 31;
   // ==========================================================
   // Types
   typedef struct packed {
      logic n;
      logic ov;
      logic z;
      logic dc;
      logic c;
   } flags_t;
   typedef enum logic [1:0] {
      ST_EXEC  = 2'b00,
      ST_WORD2 = 2'b01,
      ST_FLUSH = 2'b11,
      ST_TWAIT = 2'b10
   } dec_state_t;
   typedef enum logic [1:0] {
      PEND_CALL = 2'h0,
      PEND_JUMP = 2'h1,
      PEND_PTR  = 2'h2
   } pend_op_t;
endpackage

// ==== sim/prog_mem_model.sv ====
// Program memory model serving instruction words and table data
`timescale 1ns/1ps
module prog_mem_model (
   input  wire logic        clk_i,
   input  wire logic        slow_i,
   input  wire logic [20:0] pc_i,
   input  wire logic [20:0] tbl_addr_i,
   input  wire logic        busy_i,
   output logic      [15:0] instr_o,
   output logic             valid_o,
   output logic      [7:0]  tbl_rdata_o,
   output logic             done_o
);
   logic [15:0] mem [64];
   logic        tick;
   logic [3:0]  wait_n;
   // ==========================
   // Fetch and table data
   // Slow mode offers a word every other cycle, inverted junk otherwise
   assign valid_o     = !slow_i || tick;
   assign instr_o     = valid_o ? mem[pc_i[6:1]] : ~mem[pc_i[6:1]];
   assign tbl_rdata_o = tbl_addr_i[7:0] ^ 8'h5a;
   // Long write is terminated eight cycles after busy rises
   assign done_o      = busy_i && wait_n == 4'h8;
   initial tick = 1'b0;
   always @(posedge clk_i) begin
      tick <= !tick;
      wait_n <= busy_i ? wait_n + 4'h1 : 4'h0;
   end
endmodule

// ==== sim/control_literal_table_decoder_tb.sv ====
// Self-checking bench for the control, literal and table decoder
`timescale 1ns/1ps
module control_literal_table_decoder_tb
   import ctl_lit_pkg::*;
;
   localparam logic [7:0] OPS [7] = '{8'h0f, 8'h08, 8'h0b, 8'h09, 8'h0a, 8'h0e, 8'h0d};
   localparam int         FB [4]  = '{2, 0, 3, 4};
   localparam int         TA [4]  = '{0, 1, 3, 3};
   logic        clk_i, rst_i, cyc, stb, we, rmw, twr, tasg, slow;
   logic        ack, ivalid, trd, busy, slp, wdc, pclr, done;
   logic [7:0]  adr, pins, pout, trdat;
   logic [3:0]  sel;
   logic [31:0] dat, rd, dat_o;
   logic [20:0] pc, taddr;
   logic [15:0] instr;
   logic [31:0] seed = 32'hf21ade4f;
   int          bad_count = 0;
   int          total_checks = 0;
   int          busy_n, wdc_n;
   logic [20:0] rd_q [$];
   control_literal_table_decoder DUT (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .instr_i(instr), .instr_valid_i(ivalid), .instr_ready_o(), .pc_o(pc),
      .tbl_addr_o(taddr), .tbl_rd_o(trd), .tbl_wr_o(), .tbl_wdata_o(),
      .tbl_rdata_i(trdat), .mem_write_done_i(done), .mem_write_busy_o(busy),
      .sleep_o(slp), .wdt_clear_o(wdc), .soft_reset_o(), .port_pins_i(pins),
      .port_rmw_i(rmw), .port_rmw_data_o(pout), .timer_write_i(twr),
      .prescaler_assigned_i(tasg), .prescaler_clear_o(pclr));
   prog_mem_model pmem (.clk_i(clk_i), .slow_i(slow), .pc_i(pc), .tbl_addr_i(taddr),
      .busy_i(busy), .instr_o(instr), .valid_o(ivalid), .tbl_rdata_o(trdat), .done_o(done));
   // ==========================
   // Clock, monitors and helpers
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // Record table read addresses, busy cycles and watchdog pulses
   always @(posedge clk_i) begin
      if (rst_i) begin
         rd_q.delete();
         busy_n <= 0;
         wdc_n <= 0;
      end else begin
         if (trd === 1'b1) rd_q.push_back(taddr);
         busy_n <= busy_n + int'(busy === 1'b1);
         wdc_n <= wdc_n + int'(wdc === 1'b1);
      end
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Expected {product, flags n ov z dc c, working register} of one literal op
   function automatic logic [28:0] alu(logic [7:0] op, logic [7:0] w, logic [7:0] k,
                                       logic [4:0] f);
      logic [8:0]  s;
      logic [4:0]  h;
      logic [7:0]  b, r;
      logic [15:0] p;
      b = (op == 8'h08) ? ~w : w;
      s = k + b + (op == 8'h08);
      h = k[3:0] + b[3:0] + (op == 8'h08);
      r = w;
      p = 16'h0;
      case (op)
         8'h0f, 8'h08: begin
            r = s[7:0];
            f = {r[7], k[7] == b[7] && r[7] != k[7], r == 8'h0, h[4], s[8]};
         end
         8'h0b: r = w & k;
         8'h09: r = w | k;
         8'h0a: r = w ^ k;
         8'h0e: r = k;
         default: p = w * k;
      endcase
      if (op inside {8'h0b, 8'h09, 8'h0a}) f[4] = r[7];
      if (op inside {8'h0b, 8'h09, 8'h0a}) f[2] = r == 8'h0;
      return {p, f, r};
   endfunction
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One classic Wishbone cycle; read data lands in rd
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hf};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rd = dat_o;
      {cyc, stb} <= 2'b00;
      if (n >= 20) chk("bus ack", 32'h1, 32'h0);
   endtask
   // Reset, load a program, start the core and wait for its final loop
   task automatic run(input logic [15:0] p [$], input logic [1:0] ctl);
      int n;
      n = 0;
      foreach (p[i]) pmem.mem[i] = p[i];
      void'(rnd());
      slow <= seed[0];
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b1, ADR_CTRL, {30'h0, ctl});
      while (pc !== 21'(2 * p.size() - 2) && slp !== 1'b1 && n < 300) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 300) chk("program end", 32'h1, 32'h0);
      repeat (6) @(posedge clk_i);
   endtask
   task automatic regs(input logic [28:0] e);
      wb(1'b0, ADR_ACC, 32'h0);
      chk("work reg", 32'(e[7:0]), rd);
      wb(1'b0, ADR_STATUS, 32'h0);
      chk("flags", 32'(e[12:8]), 32'(rd[4:0]));
      wb(1'b0, ADR_PROD, 32'h0);
      chk("prod", 32'(e[28:13]), rd);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Cut a hang short
   initial begin
      #(20000 * 100);
      chk("watchdog", 32'h0, 32'h1);
      complete_run();
   end
   // ==========================
   // Scenarios
   initial begin
      logic [7:0]  a, b, c;
      logic [28:0] e;
      {rst_i, cyc, stb, we, rmw, twr, tasg, slow, adr, pins, sel, dat} = {1'b1, 59'h0};
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      // Reset values, ignored write to a read-only place, unmapped read
      wb(1'b1, ADR_ACC, 32'h5a);
      wb(1'b0, ADR_ACC, 32'h0);
      chk("work reg ro", 32'h0, rd);
      wb(1'b0, ADR_STATUS, 32'h0);
      chk("status", 32'hc0, rd);
      wb(1'b0, 8'h40, 32'h0);
      chk("unmapped", 32'h0, rd);
      // Every literal op but the literal return after an add; one corner with carry, zero and overflow
      foreach (OPS[i]) begin
         a = (i == 2) ? 8'h80 : 8'(rnd());
         b = (i == 2) ? 8'h80 : 8'(rnd());
         c = 8'(rnd());
         e = alu(8'h0f, a, b, 5'h0);
         e = alu(OPS[i], e[7:0], c, e[12:8]);
         run('{{8'h0e, a}, {8'h0f, b}, {OPS[i], c}, 16'hd7ff}, 2'h1);
         regs(e);
      end
      // Each branch condition; a taken branch skips the next word
      for (int cc = 0; cc < 8; cc++) begin
         a = 8'(rnd());
         b = 8'(rnd());
         e = alu(8'h0f, a, b, 5'h0);
         run('{{8'h0e, a}, {8'h0f, b}, {5'h1c, 3'(cc), 8'h01}, 16'h0e11, 16'hd7ff}, 2'h1);
         if (!(e[8 + FB[cc / 2]] ^ cc[0])) e[7:0] = 8'h11;
         regs(e);
      end
      // Absolute jump, stray second word, bank and pointer loads
      run('{16'hef03, 16'hf000, 16'h0e11, 16'h0e22, 16'hfabc, 16'h0105, 16'hee1a,
            16'hf0bc, 16'hd7ff}, 2'h1);
      regs(29'h22);
      wb(1'b0, ADR_BANK, 32'h0);
      chk("bank", 32'h5, rd);
      wb(1'b0, ADR_PTR1, 32'h0);
      chk("pointer", 32'habc, rd);
      // Absolute and relative calls into one subroutine, plain return
      run('{16'h0e10, 16'hd002, 16'h0f01, 16'h0012, 16'hec02, 16'hf000, 16'hdffb,
            16'hd7ff}, 2'h1);
      regs(29'h12);
      // Decimal adjust with carry out, push then pop, literal return from a relative call
      run('{16'h0e9a, 16'h0007, 16'h0005, 16'h0006, 16'hd001, 16'h0c77, 16'hdffe,
            16'hd7ff}, 2'h1);
      regs(29'h177);
      // Table reads in three pointer modes: post-increment, pre-increment and post-decrement
      run('{16'h0009, 16'h0009, 16'h000b, 16'h000a, 16'hd7ff}, 2'h1);
      chk("reads", 32'h4, rd_q.size());
      foreach (TA[i]) chk("rd addr", TA[i], 32'(rd_q[i]));
      wb(1'b0, ADR_TBLPTR, 32'h0);
      chk("tblptr", 32'h2, rd);
      wb(1'b0, ADR_TBLLAT, 32'h0);
      chk("latch", 32'h59, rd);
      // Long table write stays busy until memory terminates it
      run('{16'h000d, 16'hd7ff}, 2'h3);
      repeat (12) @(posedge clk_i);
      chk("busy cycles", 32'h9, busy_n);
      wb(1'b0, ADR_TBLPTR, 32'h0);
      chk("tblptr", 32'h1, rd);
      // Watchdog clear then standby
      run('{16'h0004, 16'h0003, 16'hd7ff}, 2'h1);
      chk("wdt pulses", 32'h1, wdc_n);
      wb(1'b0, ADR_STATUS, 32'h0);
      chk("standby", 32'h480, rd);
      // Port write-back from pins and prescaler clear on timer write
      repeat (8) begin
         pins <= 8'(rnd());
         tasg <= seed[3];
         {rmw, twr} <= 2'b11;
         @(posedge clk_i);
         {rmw, twr} <= 2'b00;
         @(negedge clk_i);
         chk("rmw data", 32'(pins), 32'(pout));
         chk("presc clr", 32'(tasg), 32'(pclr));
         @(posedge clk_i);
      end
      complete_run();
   end
endmodule
